// ===== src/swsc_pkg.sv
package swsc_pkg;
  // Register offsets on the serial register port
  localparam logic [7:0] SWSC_OFS_SYSCTL2 = 8'h2b;
  localparam logic [7:0] SWSC_OFS_IRQWAKE = 8'h2c;
  // System control two fields
  localparam int SWSC_B_SELF_TEST = 7;
  localparam int SWSC_B_SOFT_RST = 6;
  localparam int SWSC_B_SLP_OS_HI = 4;
  localparam int SWSC_B_SLP_OS_LO = 3;
  localparam int SWSC_B_AUTO_SLP = 2;
  localparam int SWSC_B_WAKE_OS_HI = 1;
  localparam int SWSC_B_WAKE_OS_LO = 0;
  // Interrupt and wake control fields
  localparam int SWSC_B_BUF_HOLD = 7;
  localparam int SWSC_B_WAKE_ON_TRANSIENT = 6;
  localparam int SWSC_B_WAKE_ORIENT = 5;
  localparam int SWSC_B_WAKE_PULSE = 4;
  localparam int SWSC_B_WAKE_FFMT = 3;
  localparam int SWSC_B_IRQ_POL = 1;
  localparam int SWSC_B_IRQ_DRV = 0;
  // Reset values
  localparam logic [7:0] SWSC_RST_SYSCTL2 = 8'h00;
  localparam logic [7:0] SWSC_RST_IRQWAKE = 8'h00;
  // Writable masks (bit 5 of control two and bit 2 of wake control unused)
  localparam logic [7:0] SWSC_WMASK_SYSCTL2 = 8'hdf;
  localparam logic [7:0] SWSC_WMASK_IRQWAKE = 8'hfb;
  // Boot length after a soft reset, in cycles of clk_in
  localparam int SWSC_BOOT_NS = 500;
  localparam int SWSC_CLK_NS = 50;
  localparam int SWSC_BOOT_CYC = (SWSC_BOOT_NS + SWSC_CLK_NS - 1) / SWSC_CLK_NS;
  localparam int SWSC_NUM_IRQ = 2;
  // Oversampling schemes
  typedef enum logic [1:0] {
    SWSC_OS_NORMAL = 2'b00,
    SWSC_OS_LNLP = 2'b01,
    SWSC_OS_HIRES = 2'b10,
    SWSC_OS_LOWPWR = 2'b11
  } swsc_os_t;
  // Power state, Gray coded along standby-wake-sleep
  typedef enum logic [1:0] {
    SWSC_ST_STANDBY = 2'b00,
    SWSC_ST_WAKE = 2'b01,
    SWSC_ST_SLEEP = 2'b11
  } swsc_mode_t;
endpackage

// ===== src/swsc_sync.sv
`timescale 1ns/1ns
// Three-stage synchroniser; a change counts once stages two and three agree
module swsc_sync
  import swsc_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          q_out[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          q_out[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule

// ===== src/swsc_irq_pad.sv
`timescale 1ns/1ns
// One interrupt pad: polarity and drive type applied to an active-high request
module swsc_irq_pad
  import swsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic pol_high_in,
  input wire logic open_drain_in,
  output logic pad_o_out,
  output logic pad_oe_out
);
  logic lvl;
  assign lvl = pol_high_in ? req_in : ~req_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_o_out <= 1'b1;
      pad_oe_out <= 1'b1;
    end else begin
      // Open drain only pulls low, so an idle high level is left to the pull-up
      pad_o_out <= open_drain_in ? 1'b0 : lvl;
      pad_oe_out <= open_drain_in ? ~lvl : 1'b1;
    end
  end
endmodule

// ===== src/swsc_top.sv
`timescale 1ns/1ns
// How it works
// - Self-test bit set drives the axis stimulus; clearing removes it.
// - Writing one to soft reset resets at once and reloads all defaults.
// - Soft reset also resets the serial register port logic.
// - Soft reset bit clears after boot and always reads zero.
// - Two 2-bit oversampling fields, wake and sleep, default normal.
// - Oversampling ratio follows scheme and sample rate, e.g. 1024 high-res.
// - Auto-sleep enable resets to zero; zero forbids automatic sleep.
// - Buffer hold zero: flush FIFO on every wake/sleep change.
// - Buffer hold one: keep FIFO, drop samples until host empties it.
// - Sample during hold before emptying sets error flag until emptied.
// - Four wake source bits let their interrupts wake from sleep.
// - Polarity bit zero active low, one active high.
// - Drive bit zero push-pull, one open drain.
// - Wake control layout: hold 7, wake 6..3, unused 2, pol 1, drive 0.
// - Auto-sleep after programmed inactivity switches to sleep rate.
module swsc_top
  import swsc_pkg::*;
#(
  parameter int RATE_W = 3
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Serial register port, decoded byte accesses
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  output logic bus_reset_out,
  // Power mode control
  input wire logic active_in,
  input wire logic inactivity_done_in,
  input wire logic [RATE_W-1:0] wake_rate_in,
  input wire logic [RATE_W-1:0] sleep_rate_in,
  // Function events and sample timing
  input wire logic evt_transient_in,
  input wire logic evt_orientation_in,
  input wire logic evt_pulse_in,
  input wire logic evt_freefall_motion_in,
  input wire logic sample_tick_in,
  input wire logic fifo_empty_in,
  input wire logic [SWSC_NUM_IRQ-1:0] irq_req_in,
  // Outputs to the sensing path and FIFO
  output logic self_test_stim_out,
  output logic [1:0] os_scheme_out,
  output logic [10:0] os_ratio_out,
  output logic [RATE_W-1:0] output_sample_rate_out,
  output logic [1:0] system_mode_status_out,
  output logic buffer_hold_error_out,
  output logic fifo_flush_out,
  output logic fifo_accept_out,
  output logic booting_out,
  // Interrupt pads
  output logic [SWSC_NUM_IRQ-1:0] irq_pad_o_out,
  output logic [SWSC_NUM_IRQ-1:0] irq_pad_oe_out
);
  logic self_test_enable_r;
  logic [1:0] sleep_oversampling_scheme_r;
  logic auto_sleep_enable_r;
  logic [1:0] wake_oversampling_scheme_r;
  logic [7:0] interrupt_wake_control_r;
  logic soft_rst_r;
  logic [7:0] boot_cnt_r;
  swsc_mode_t mode_r;
  swsc_mode_t mode_nxt;
  logic hold_r;
  logic buffer_hold_error_r;
  logic flush_r;
  logic [7:0] rdata_r;
  logic hit_r;
  logic [3:0] evt_sync;
  logic wake_evt;
  logic [7:0] sysctl2_rd;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs);
    sel = (a == ofs);
  endfunction

  // Asynchronous events from the detection functions
  swsc_sync #(.W(4)) u_evt_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in({evt_transient_in, evt_orientation_in, evt_pulse_in, evt_freefall_motion_in}),
    .q_out(evt_sync)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= reg_wr_in && !booting_out && sel(reg_addr_in, SWSC_OFS_SYSCTL2)
        && reg_wdata_in[SWSC_B_SOFT_RST];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_cnt_r <= 8'h00;
    end else if (soft_rst_r) begin
      boot_cnt_r <= 8'(SWSC_BOOT_CYC);
    end else if (boot_cnt_r != 8'h00) begin
      boot_cnt_r <= boot_cnt_r - 8'h01;
    end
  end
  assign booting_out = soft_rst_r || (boot_cnt_r != 8'h00);
  assign bus_reset_out = booting_out;

  // register writes, defaults on soft reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      self_test_enable_r <= SWSC_RST_SYSCTL2[SWSC_B_SELF_TEST];
      sleep_oversampling_scheme_r <= SWSC_RST_SYSCTL2[SWSC_B_SLP_OS_HI:SWSC_B_SLP_OS_LO];
      auto_sleep_enable_r <= SWSC_RST_SYSCTL2[SWSC_B_AUTO_SLP];
      wake_oversampling_scheme_r <= SWSC_RST_SYSCTL2[SWSC_B_WAKE_OS_HI:SWSC_B_WAKE_OS_LO];
    end else if (booting_out) begin
      self_test_enable_r <= SWSC_RST_SYSCTL2[SWSC_B_SELF_TEST];
      sleep_oversampling_scheme_r <= SWSC_RST_SYSCTL2[SWSC_B_SLP_OS_HI:SWSC_B_SLP_OS_LO];
      auto_sleep_enable_r <= SWSC_RST_SYSCTL2[SWSC_B_AUTO_SLP];
      wake_oversampling_scheme_r <= SWSC_RST_SYSCTL2[SWSC_B_WAKE_OS_HI:SWSC_B_WAKE_OS_LO];
    end else if (reg_wr_in && sel(reg_addr_in, SWSC_OFS_SYSCTL2)
                 && !reg_wdata_in[SWSC_B_SOFT_RST]) begin
      self_test_enable_r <= reg_wdata_in[SWSC_B_SELF_TEST];
      sleep_oversampling_scheme_r <= reg_wdata_in[SWSC_B_SLP_OS_HI:SWSC_B_SLP_OS_LO];
      auto_sleep_enable_r <= reg_wdata_in[SWSC_B_AUTO_SLP];
      wake_oversampling_scheme_r <= reg_wdata_in[SWSC_B_WAKE_OS_HI:SWSC_B_WAKE_OS_LO];
    end
  end

  // wake control register, unused bit held at zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_wake_control_r <= SWSC_RST_IRQWAKE;
    end else if (booting_out) begin
      interrupt_wake_control_r <= SWSC_RST_IRQWAKE;
    end else if (reg_wr_in && sel(reg_addr_in, SWSC_OFS_IRQWAKE)) begin
      interrupt_wake_control_r <= reg_wdata_in & SWSC_WMASK_IRQWAKE;
    end
  end

  // soft reset bit always reads zero
  always_comb begin
    sysctl2_rd = 8'h00;
    sysctl2_rd[SWSC_B_SELF_TEST] = self_test_enable_r;
    sysctl2_rd[SWSC_B_SLP_OS_HI:SWSC_B_SLP_OS_LO] = sleep_oversampling_scheme_r;
    sysctl2_rd[SWSC_B_AUTO_SLP] = auto_sleep_enable_r;
    sysctl2_rd[SWSC_B_WAKE_OS_HI:SWSC_B_WAKE_OS_LO] = wake_oversampling_scheme_r;
  end

  // Read data registered one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
    end else if (booting_out) begin
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
    end else if (reg_rd_in) begin
      hit_r <= sel(reg_addr_in, SWSC_OFS_SYSCTL2) || sel(reg_addr_in, SWSC_OFS_IRQWAKE);
      if (sel(reg_addr_in, SWSC_OFS_SYSCTL2)) begin
        rdata_r <= sysctl2_rd;
      end else if (sel(reg_addr_in, SWSC_OFS_IRQWAKE)) begin
        rdata_r <= interrupt_wake_control_r;
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end
  assign reg_rdata_out = rdata_r;
  assign reg_hit_out = hit_r;

  assign self_test_stim_out = self_test_enable_r;

  // only enabled sources wake the device
  assign wake_evt =
      (interrupt_wake_control_r[SWSC_B_WAKE_ON_TRANSIENT] && evt_sync[3])
    || (interrupt_wake_control_r[SWSC_B_WAKE_ORIENT] && evt_sync[2])
    || (interrupt_wake_control_r[SWSC_B_WAKE_PULSE] && evt_sync[1])
    || (interrupt_wake_control_r[SWSC_B_WAKE_FFMT] && evt_sync[0]);

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      SWSC_ST_STANDBY: begin
        if (active_in) begin
          mode_nxt = SWSC_ST_WAKE;
        end
      end
      SWSC_ST_WAKE: begin
        if (!active_in) begin
          mode_nxt = SWSC_ST_STANDBY;
        end else if (auto_sleep_enable_r && inactivity_done_in) begin
          mode_nxt = SWSC_ST_SLEEP;
        end
      end
      SWSC_ST_SLEEP: begin
        if (!active_in) begin
          mode_nxt = SWSC_ST_STANDBY;
        end else if (wake_evt || !auto_sleep_enable_r) begin
          mode_nxt = SWSC_ST_WAKE;
        end
      end
      default: mode_nxt = SWSC_ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r <= SWSC_ST_STANDBY;
    end else if (booting_out) begin
      mode_r <= SWSC_ST_STANDBY;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  logic ws_change;
  assign ws_change = (mode_r != mode_nxt) && (mode_r != SWSC_ST_STANDBY)
    && (mode_nxt != SWSC_ST_STANDBY);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flush_r <= 1'b0;
      hold_r <= 1'b0;
      buffer_hold_error_r <= 1'b0;
    end else if (booting_out) begin
      flush_r <= 1'b0;
      hold_r <= 1'b0;
      buffer_hold_error_r <= 1'b0;
    end else begin
      flush_r <= ws_change && !interrupt_wake_control_r[SWSC_B_BUF_HOLD];
      if (ws_change && interrupt_wake_control_r[SWSC_B_BUF_HOLD] && !fifo_empty_in) begin
        hold_r <= 1'b1;
      end else if (fifo_empty_in) begin
        hold_r <= 1'b0;
      end
      // Emptying clears the flag; a sample in the same cycle cannot land in an empty FIFO
      if (fifo_empty_in) begin
        buffer_hold_error_r <= 1'b0;
      end else if (hold_r && sample_tick_in) begin
        buffer_hold_error_r <= 1'b1;
      end
    end
  end
  assign fifo_flush_out = flush_r;
  assign fifo_accept_out = !hold_r && !booting_out;
  assign buffer_hold_error_out = buffer_hold_error_r;
  assign system_mode_status_out = (mode_r == SWSC_ST_SLEEP) ? 2'b10 :
    (mode_r == SWSC_ST_WAKE) ? 2'b01 : 2'b00;

  // scheme and rate by current mode
  assign os_scheme_out = (mode_r == SWSC_ST_SLEEP) ? sleep_oversampling_scheme_r
    : wake_oversampling_scheme_r;
  assign output_sample_rate_out = (mode_r == SWSC_ST_SLEEP) ? sleep_rate_in : wake_rate_in;

  // oversampling ratio table, log2 by rate (0 = 800 Hz .. 7 = 1.56 Hz)
  function automatic logic [10:0] os_ratio(input logic [1:0] s, input logic [2:0] r);
    logic [3:0] lg;
    lg = 4'd1;
    unique case (s)
      2'b00: lg = (r == 3'd7) ? 4'd7 : (r == 3'd6) ? 4'd5 : (r == 3'd5) ? 4'd4
        : (r == 3'd0) ? 4'd1 : 4'd2;
      2'b01: lg = (r == 3'd7) ? 4'd5 : (r == 3'd6) ? 4'd3 : (r == 3'd0) ? 4'd1 : 4'd2;
      2'b10: lg = (r == 3'd7) ? 4'd10 : (r == 3'd6) ? 4'd8 : (r == 3'd5) ? 4'd7
        : (r == 3'd4) ? 4'd5 : (r == 3'd3) ? 4'd4 : (r == 3'd2) ? 4'd3
        : (r == 3'd1) ? 4'd2 : 4'd1;
      2'b11: lg = (r == 3'd7) ? 4'd4 : (r == 3'd6) ? 4'd2 : 4'd1;
    endcase
    os_ratio = 11'h001 << lg;
  endfunction

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      os_ratio_out <= 11'h002;
    end else begin
      os_ratio_out <= os_ratio(os_scheme_out, 3'(output_sample_rate_out));
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SWSC_NUM_IRQ; gi++) begin : g_pad
      swsc_irq_pad u_pad (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .req_in(irq_req_in[gi]),
        .pol_high_in(interrupt_wake_control_r[SWSC_B_IRQ_POL]),
        .open_drain_in(interrupt_wake_control_r[SWSC_B_IRQ_DRV]),
        .pad_o_out(irq_pad_o_out[gi]),
        .pad_oe_out(irq_pad_oe_out[gi])
      );
    end
  endgenerate
endmodule

// ===== test/swsc_checker.sv
`timescale 1ns/1ns
module swsc_checker
  import swsc_pkg::*;
#(
  parameter int RATE_W = 3
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_hit_out,
  input wire logic bus_reset_out,
  // Mode, FIFO and sensing
  input wire logic booting_out,
  input wire logic self_test_stim_out,
  input wire logic fifo_empty_in,
  input wire logic buffer_hold_error_out,
  input wire logic fifo_flush_out,
  input wire logic fifo_accept_out,
  input wire logic [1:0] system_mode_status_out,
  input wire logic [RATE_W-1:0] sleep_rate_in,
  input wire logic [RATE_W-1:0] output_sample_rate_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  rd_rst_zero_a: assert property (
    reg_rd_in && !booting_out |=> !reg_rdata_out[SWSC_B_SOFT_RST])
    else $error("soft reset bit read as one");
  soft_rst_boot_a: assert property (
    reg_wr_in && !booting_out && reg_addr_in == SWSC_OFS_SYSCTL2
    && reg_wdata_in[SWSC_B_SOFT_RST] |=> booting_out [*8])
    else $error("soft reset did not start boot");
  boot_bus_rst_a: assert property (
    booting_out |-> bus_reset_out)
    else $error("serial port not reset during boot");
  boot_no_accept_a: assert property (
    booting_out |-> !fifo_accept_out)
    else $error("samples accepted during boot");
  self_test_a: assert property (
    reg_wr_in && !booting_out && reg_addr_in == SWSC_OFS_SYSCTL2
    && !reg_wdata_in[SWSC_B_SOFT_RST]
    |=> self_test_stim_out == $past(reg_wdata_in[SWSC_B_SELF_TEST]))
    else $error("self-test stimulus does not follow write");
  unmapped_rd_a: assert property (
    reg_rd_in && !booting_out && reg_addr_in != SWSC_OFS_SYSCTL2
    && reg_addr_in != SWSC_OFS_IRQWAKE |=> reg_rdata_out == 8'h00 && !reg_hit_out)
    else $error("unmapped read not refused");
  flush_pulse_a: assert property (
    fifo_flush_out |=> !fifo_flush_out)
    else $error("flush longer than one cycle");
  err_clear_a: assert property (
    fifo_empty_in |=> !buffer_hold_error_out)
    else $error("hold error kept with empty FIFO");
  sleep_rate_a: assert property (
    system_mode_status_out == 2'b10 && $stable(system_mode_status_out)
    |-> output_sample_rate_out == sleep_rate_in)
    else $error("sleep mode not at sleep rate");
endmodule

bind swsc_top swsc_checker #(.RATE_W(RATE_W)) swsc_checker_inst (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_hit_out(reg_hit_out), .bus_reset_out(bus_reset_out), .booting_out(booting_out),
  .self_test_stim_out(self_test_stim_out), .fifo_empty_in(fifo_empty_in),
  .buffer_hold_error_out(buffer_hold_error_out), .fifo_flush_out(fifo_flush_out),
  .fifo_accept_out(fifo_accept_out), .system_mode_status_out(system_mode_status_out),
  .sleep_rate_in(sleep_rate_in), .output_sample_rate_out(output_sample_rate_out));

// ===== test/swsc_host.sv
`timescale 1ns/1ns
module swsc_host (
  // Clock
  input wire logic clk_in,
  // Register port
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_hit_in
);
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat ($urandom_range(1, 2)) @(posedge clk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    repeat ($urandom_range(1, 2)) @(posedge clk_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    #1;
    d = reg_rdata_in;
    h = reg_hit_in;
  endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ns
module testbench
  import swsc_pkg::*;
;
  logic clk_in, rst_n_in, wr, rd, hit, act, inact, tick, empty, h;
  logic st, err, flush, accept, boot, bus_rst;
  logic [7:0] addr, wdata, rdata, d, v, m_ctl;
  logic [2:0] wrate, srate, rate;
  logic [3:0] evt;
  logic [1:0] ireq, os, mode, pad_o, pad_oe;
  logic [10:0] ratio;
  int fails, check_count, flushes, f0;
  int rt[4][8] = '{'{2, 4, 4, 4, 4, 16, 32, 128}, '{2, 4, 4, 4, 4, 4, 8, 32},
    '{2, 4, 8, 16, 32, 128, 256, 1024}, '{2, 2, 2, 2, 2, 2, 4, 16}};

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) flushes <= flushes + int'(flush === 1'b1);

  swsc_top #(.RATE_W(3)) swsc_top_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit),
    .bus_reset_out(bus_rst), .active_in(act), .inactivity_done_in(inact),
    .wake_rate_in(wrate), .sleep_rate_in(srate), .evt_transient_in(evt[3]),
    .evt_orientation_in(evt[2]), .evt_pulse_in(evt[1]), .evt_freefall_motion_in(evt[0]),
    .sample_tick_in(tick), .fifo_empty_in(empty), .irq_req_in(ireq),
    .self_test_stim_out(st), .os_scheme_out(os), .os_ratio_out(ratio),
    .output_sample_rate_out(rate), .system_mode_status_out(mode),
    .buffer_hold_error_out(err), .fifo_flush_out(flush), .fifo_accept_out(accept),
    .booting_out(boot), .irq_pad_o_out(pad_o), .irq_pad_oe_out(pad_oe));
  swsc_host swsc_host_inst (.clk_in(clk_in), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_hit_in(hit));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Bounded wait on the mode (sel 0) or on boot end (sel 1)
  task automatic wait_for(input bit sel, input logic [1:0] m);
    int n;
    n = 0;
    // Looks just after each edge, once the design has settled
    while ((sel ? {1'b0, boot} : mode) !== m && n < 80) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if ((sel ? {1'b0, boot} : mode) !== m) begin
      fails++;
      $display("[ERR] %0t wait timed out", $time);
      print_verdict();
    end
  endtask

  initial begin
    rst_n_in = 1'b0;
    {act, inact, tick, empty, evt, ireq, wrate, srate} = '0;
    void'($urandom(32'h3b37));
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    swsc_host_inst.rd(SWSC_OFS_SYSCTL2, d, h);
    chk(d, 8'h00);
    swsc_host_inst.rd(SWSC_OFS_IRQWAKE, d, h);
    chk(d, 8'h00);
    swsc_host_inst.rd(8'h2a, d, h);
    chk({h, d}, 9'h000);
    chk({pad_o, pad_oe}, 4'hf);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      m_ctl = 8'($urandom()) & 8'hbf & SWSC_WMASK_SYSCTL2;
      swsc_host_inst.wr(SWSC_OFS_SYSCTL2, m_ctl | 8'h20);
      #1 chk(st, m_ctl[7]);
      chk(os, m_ctl[1:0]);
      swsc_host_inst.rd(SWSC_OFS_SYSCTL2, d, h);
      chk(d, m_ctl);
      v = 8'($urandom());
      swsc_host_inst.wr(SWSC_OFS_IRQWAKE, v);
      swsc_host_inst.rd(SWSC_OFS_IRQWAKE, d, h);
      chk({h, d}, {1'b1, v & 8'hfb});
    end
    $display("register test done");
    for (int s = 0; s < 4; s++) begin
      swsc_host_inst.wr(SWSC_OFS_SYSCTL2, 8'(s));
      for (int r = 0; r < 8; r++) begin
        @(posedge clk_in) wrate <= 3'(r);
        repeat (3) @(posedge clk_in);
        #1 chk(ratio, 16'(rt[s][r]));
      end
    end
    $display("ratio test done");
    for (int c = 0; c < 8; c++) begin
      swsc_host_inst.wr(SWSC_OFS_IRQWAKE, 8'(c % 4));
      @(posedge clk_in) ireq <= {2{c[2]}};
      repeat (3) @(posedge clk_in);
      // Open drain drives only the low level, so the enable is the inverse of the pin level
      #1 chk(pad_oe, {2{c[0] ? c[1] ^ c[2] : 1'b1}});
      chk(pad_o, {2{c[0] ? 1'b0 : ~(c[1] ^ c[2])}});
    end
    @(posedge clk_in) ireq <= 2'b00;
    $display("pad test done");
    swsc_host_inst.wr(SWSC_OFS_IRQWAKE, 8'h00);
    swsc_host_inst.wr(SWSC_OFS_SYSCTL2, 8'h00);
    @(posedge clk_in) wrate <= 3'($urandom_range(0, 3));
    srate <= 3'($urandom_range(4, 7));
    act <= 1'b1;
    inact <= 1'b1;
    wait_for(0, 2'b01);
    repeat (20) @(posedge clk_in);
    #1 chk(mode, 2'b01);
    swsc_host_inst.wr(SWSC_OFS_SYSCTL2, 8'h15);
    wait_for(0, 2'b10);
    chk(rate, srate);
    chk(os, 2'b10);
    // Let the flush of this change be counted before the baseline is taken
    repeat (2) @(posedge clk_in);
    #1 f0 = flushes;
    chk(ratio, 16'(rt[2][srate]));
    for (int i = 0; i < 4; i++) begin
      swsc_host_inst.wr(SWSC_OFS_IRQWAKE, 8'h00);
      @(posedge clk_in) inact <= 1'b0;
      evt <= 4'(4'h1 << i);
      repeat (12) @(posedge clk_in);
      #1 chk(mode, 2'b10);
      // The synchroniser tail must drain, or a stale event would wake the device
      @(posedge clk_in) evt <= 4'h0;
      repeat (5) @(posedge clk_in);
      swsc_host_inst.wr(SWSC_OFS_IRQWAKE, 8'(8'h08 << i));
      @(posedge clk_in) evt <= 4'(4'h1 << i);
      wait_for(0, 2'b01);
      chk(rate, wrate);
      chk(os, 2'b01);
      @(posedge clk_in) evt <= 4'h0;
      repeat (6) @(posedge clk_in);
      inact <= 1'b1;
      wait_for(0, 2'b10);
    end
    repeat (2) @(posedge clk_in);
    #1 chk(16'(flushes - f0), 16'd8);
    swsc_host_inst.wr(SWSC_OFS_IRQWAKE, 8'hc0);
    @(posedge clk_in) empty <= 1'b0;
    inact <= 1'b0;
    evt <= 4'h8;
    wait_for(0, 2'b01);
    repeat (2) @(posedge clk_in);
    #1 chk(accept, 1'b0);
    chk(16'(flushes - f0), 16'd8);
    @(posedge clk_in) tick <= 1'b1;
    evt <= 4'h0;
    @(posedge clk_in) tick <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk(err, 1'b1);
    @(posedge clk_in) empty <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 chk({err, accept}, 2'b01);
    $display("mode test done");
    swsc_host_inst.wr(SWSC_OFS_SYSCTL2, 8'hc4);
    #1 chk({boot, bus_rst}, 2'b11);
    swsc_host_inst.wr(SWSC_OFS_IRQWAKE, 8'hff);
    wait_for(1, 2'b00);
    swsc_host_inst.rd(SWSC_OFS_SYSCTL2, d, h);
    chk({d, st}, 9'h000);
    swsc_host_inst.rd(SWSC_OFS_IRQWAKE, d, h);
    chk(d, SWSC_RST_IRQWAKE);
    $display("soft reset test done");
    print_verdict();
  end
endmodule
